// *** hdl/ddrc_pkg.sv ***
// shared constants, encodings and carrier types of the ddr3 command decoder
package ddrc_pkg;

    // bus widths
    localparam int BANKS = 8;
    localparam int BA_W = 3;
    localparam int ADDR_W = 13;
    localparam int ROW_W = 12;
    localparam int COL_W = 10;
    localparam int DQ_W = 16;
    localparam int DM_W = 2;

    // address bits with a special meaning
    localparam int AP_BIT = 10;   // auto precharge / all banks / long calibration
    localparam int BC_BIT = 12;   // burst chop select, low means four beats

    // command codes as {ras_n, cas_n, we_n} with chip select low
    localparam logic [2:0] CODE_MRS = 3'h0;
    localparam logic [2:0] CODE_REF = 3'h1;
    localparam logic [2:0] CODE_PRE = 3'h2;
    localparam logic [2:0] CODE_ACT = 3'h3;
    localparam logic [2:0] CODE_WR = 3'h4;
    localparam logic [2:0] CODE_RD = 3'h5;
    localparam logic [2:0] CODE_ZQ = 3'h6;
    localparam logic [2:0] CODE_NOP = 3'h7;

    // burst field of mode register 0
    localparam logic [BA_W-1:0] MR0_SEL = 3'h0;
    localparam int MR_BL_LSB = 0;
    localparam int MR_BL_W = 2;
    localparam int MR_BT_BIT = 3;
    localparam logic [1:0] MR_BL_FIX8 = 2'h0;
    localparam logic [1:0] MR_BL_OTF = 2'h1;
    localparam logic [1:0] MR_BL_FIX4 = 2'h2;
    localparam logic [1:0] MR_BL_RESET = MR_BL_FIX8;
    localparam logic MR_BT_RESET = 1'b0;

    // burst timing in clocks, two data words per clock
    localparam logic [1:0] LAST_BL8 = 2'h3;
    localparam logic [1:0] LAST_BC4 = 2'h1;

    // decoded operations
    typedef enum logic [3:0] {
        OP_NOP, OP_ACT, OP_PRE, OP_PREA, OP_WR, OP_RD, OP_MRS, OP_REF,
        OP_SRE, OP_SRX, OP_PDE, OP_PDX, OP_ZQL, OP_ZQS
    } ddrc_op_e;

    // power state of the device
    typedef enum logic [1:0] {
        PS_ON, PS_PDOWN, PS_SREF
    } ddrc_pwr_e;

    // one accepted command
    typedef struct packed {
        ddrc_op_e op;
        logic [BA_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic ap;
        logic bc4;
    } ddrc_cmd_s;

    // one data word of a burst with its column and byte enables
    typedef struct packed {
        logic [DQ_W-1:0] data;
        logic [DM_W-1:0] be;
        logic [COL_W-1:0] col;
    } ddrc_beat_s;

endpackage

// *** hdl/ddrc_burst_seq.sv ***
// burst column sequencer: two column addresses per clock for bl8 or bc4
module ddrc_burst_seq #(
    parameter int COL_W = 10
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // burst start
    input wire logic start,
    input wire logic [COL_W-1:0] start_col,
    input wire logic bc4,
    input wire logic interleave,
    // current pair of beats
    output logic busy,
    output logic last,
    output logic [COL_W-1:0] col0,
    output logic [COL_W-1:0] col1
);
    import ddrc_pkg::*;

    logic busy_reg;                  // a burst is running
    logic [1:0] cnt_reg;             // clock index within the burst
    logic bc4_reg;                   // chopped burst
    logic il_reg;                    // interleaved ordering
    logic [COL_W-1:0] base_reg;      // starting column

    // column of beat i; low bits wrap inside the nibble, bit 2 toggles the half
    function automatic logic [COL_W-1:0] beat_col(input logic [COL_W-1:0] base, input logic [2:0] i,
                                                  input logic il);
        logic [1:0] lo;
        lo = il ? (base[1:0] ^ i[1:0]) : 2'(base[1:0] + i[1:0]);
        return {base[COL_W-1:3], base[2] ^ i[2], lo};
    endfunction

    wire [1:0] last_cnt = bc4_reg ? LAST_BC4 : LAST_BL8;
    assign busy = busy_reg;
    assign last = busy_reg & (cnt_reg == last_cnt);
    assign col0 = beat_col(base_reg, {cnt_reg, 1'b0}, il_reg);
    assign col1 = beat_col(base_reg, {cnt_reg, 1'b1}, il_reg);

    // a new start restarts the burst, so the controller keeps bursts apart
    always_ff @(posedge clock) begin
        if (!nrst) begin
            busy_reg <= 1'b0;
            cnt_reg <= 2'h0;
            bc4_reg <= 1'b0;
            il_reg <= 1'b0;
            base_reg <= '0;
        end else if (start) begin
            busy_reg <= 1'b1;
            cnt_reg <= 2'h0;
            bc4_reg <= bc4;
            il_reg <= interleave;
            base_reg <= start_col;
        end else begin
            busy_reg <= busy_reg & ~last;   // four clocks for bl8, two for bc4
            cnt_reg <= busy_reg ? 2'(cnt_reg + 2'h1) : 2'h0;
        end
    end
endmodule

// *** hdl/ddrc_decoder.sv ***
// ddr3 command decoder with bank tracking, power states and burst sequencing
// Behaviour
// - chip select high means deselect, ignored
// - activate or precharge chosen by we_n
// - write needs cke high twice, open bank
// - a12 low chops burst to four
// - write with a10 auto precharges bank
// - read needs cke high and open bank
// - read with a10 auto precharges bank
// - mode set needs all banks idle
// - cke falling with nop enters power-down
// - cke rising with nop exits power-down
// - cke compared with previous cycle level
// - mask high discards a write byte
// - each mask covers its own byte
// - idle or active tracked per bank
// - bank from ba, row from a0-a11
// - bursts of eight or four, sequential or interleaved
// - two data words per clock, four clocks for bl8, two for bc4
// - a12 honoured only when on-the-fly enabled
module ddrc_decoder (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // command bus
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [ddrc_pkg::BA_W-1:0] ba,
    input wire logic [ddrc_pkg::ADDR_W-1:0] addr,
    // write data, rising and falling half of each clock
    input wire logic [ddrc_pkg::DQ_W-1:0] dq_rise,
    input wire logic [ddrc_pkg::DQ_W-1:0] dq_fall,
    input wire logic [ddrc_pkg::DM_W-1:0] dm_rise,
    input wire logic [ddrc_pkg::DM_W-1:0] dm_fall,
    // decoded command
    output logic cmd_valid,
    output ddrc_pkg::ddrc_cmd_s cmd,
    output logic cmd_illegal,
    // device state
    output logic [ddrc_pkg::BANKS-1:0] bank_open,
    output logic power_down,
    output logic self_refresh,
    // write beats to the array
    output logic wr_valid,
    output logic [ddrc_pkg::BA_W-1:0] wr_bank,
    output ddrc_pkg::ddrc_beat_s wr_beat0,
    output ddrc_pkg::ddrc_beat_s wr_beat1,
    // read column requests to the array
    output logic rd_valid,
    output logic [ddrc_pkg::BA_W-1:0] rd_bank,
    output logic [ddrc_pkg::COL_W-1:0] rd_col0,
    output logic [ddrc_pkg::COL_W-1:0] rd_col1
);
    import ddrc_pkg::*;

    // state registers
    logic cke_prev_reg;                    // cke level one clock back
    ddrc_pwr_e pwr_reg;                    // power state
    logic [BANKS-1:0] bank_open_reg;       // one open flag per bank
    logic [MR_BL_W-1:0] mr_bl_reg;         // burst length field
    logic mr_bt_reg;                       // burst type, high is interleave
    logic burst_wr_reg;                    // running burst is a write
    logic [BA_W-1:0] burst_bank_reg;       // bank of the running burst
    logic burst_ap_reg;                    // running burst auto precharges
    // output registers
    logic cmd_valid_reg;
    ddrc_cmd_s cmd_reg;
    logic cmd_illegal_reg;
    logic wr_valid_reg;
    logic [BA_W-1:0] wr_bank_reg;
    ddrc_beat_s wr_beat0_reg;
    ddrc_beat_s wr_beat1_reg;
    logic rd_valid_reg;
    logic [BA_W-1:0] rd_bank_reg;
    logic [COL_W-1:0] rd_col0_reg;
    logic [COL_W-1:0] rd_col1_reg;
    logic power_down_reg;                  // power-down level, registered for the pin
    logic self_refresh_reg;                // self refresh level, registered for the pin

    // sequencer outputs
    logic seq_busy;
    logic seq_last;
    logic [COL_W-1:0] seq_col0;
    logic [COL_W-1:0] seq_col1;

    // command code and chip select
    wire sel = ~cs_n;
    wire [2:0] code = {ras_n, cas_n, we_n};
    wire is_nop = sel & (code == CODE_NOP);
    wire idle_cmd = cs_n | is_nop;

    // commands only count with cke high now and one clock back
    wire cmd_en = cke_prev_reg & cke & (pwr_reg == PS_ON);

    // raw command decode
    wire is_act = cmd_en & sel & (code == CODE_ACT);
    wire is_pre = cmd_en & sel & (code == CODE_PRE);
    wire is_wr = cmd_en & sel & (code == CODE_WR);
    wire is_rd = cmd_en & sel & (code == CODE_RD);
    wire is_mrs = cmd_en & sel & (code == CODE_MRS);
    wire is_ref = cmd_en & sel & (code == CODE_REF);
    wire is_zq = cmd_en & sel & (code == CODE_ZQ);
    wire do_nop = cmd_en & is_nop;
    // legality against the addressed bank or all banks
    wire sel_open = bank_open_reg[ba];
    wire all_idle = (bank_open_reg == '0);
    wire ok_act = is_act & ~sel_open;
    wire ok_pre1 = is_pre & ~addr[AP_BIT];
    wire ok_prea = is_pre & addr[AP_BIT];
    wire ok_wr = is_wr & sel_open;
    wire ok_rd = is_rd & sel_open;
    wire ok_mrs = is_mrs & all_idle;
    wire ok_ref = is_ref & all_idle;
    wire ok_zq = is_zq & all_idle;

    // cke edges decide the power transitions
    wire cke_fall = cke_prev_reg & ~cke & (pwr_reg == PS_ON);
    wire cke_rise = ~cke_prev_reg & cke & idle_cmd;
    wire do_sre = cke_fall & sel & (code == CODE_REF) & all_idle;
    wire do_pde = cke_fall & idle_cmd;
    wire do_pdx = cke_rise & (pwr_reg == PS_PDOWN);
    wire do_srx = cke_rise & (pwr_reg == PS_SREF);

    // a command that was decoded but is not allowed here
    wire raw_cmd = is_act | is_wr | is_rd | is_mrs | is_ref | is_zq;
    wire ok_cmd = ok_act | ok_wr | ok_rd | ok_mrs | ok_ref | ok_zq;
    wire bad = (raw_cmd & ~ok_cmd) | (cke_fall & ~do_sre & ~do_pde);

    // burst length: a12 only when on-the-fly is programmed
    wire otf = (mr_bl_reg == MR_BL_OTF);
    wire use_bc4 = otf ? ~addr[BC_BIT] : (mr_bl_reg == MR_BL_FIX4);
    wire rw_start = ok_wr | ok_rd;
    // auto precharge closes the bank when its burst finishes
    wire ap_close = seq_last & burst_ap_reg;
    // operation reported for this cycle
    wire fire = ok_act | ok_pre1 | ok_prea | ok_cmd | do_nop | do_sre | do_srx | do_pde | do_pdx;
    wire ddrc_op_e op_next = ok_act ? OP_ACT :
                             ok_pre1 ? OP_PRE :
                             ok_prea ? OP_PREA :
                             ok_wr ? OP_WR :
                             ok_rd ? OP_RD :
                             ok_mrs ? OP_MRS :
                             ok_ref ? OP_REF :
                             ok_zq ? (addr[AP_BIT] ? OP_ZQL : OP_ZQS) :
                             do_sre ? OP_SRE :
                             do_srx ? OP_SRX :
                             do_pde ? OP_PDE :
                             do_pdx ? OP_PDX : OP_NOP;
    wire ddrc_cmd_s cmd_next = '{op: op_next, bank: ba, addr: addr,
                                 ap: addr[AP_BIT], bc4: use_bc4};
    // power state next value
    wire ddrc_pwr_e pwr_next = do_sre ? PS_SREF :
                               do_pde ? PS_PDOWN :
                               (do_pdx | do_srx) ? PS_ON : pwr_reg;

    // per-bank open flag; precharge and auto close first, activate last
    logic [BANKS-1:0] bank_open_next;
    for (genvar b = 0; b < BANKS; b++) begin : g_bank
        wire hit = (ba == BA_W'(b));
        wire close = ok_prea | (ok_pre1 & hit) | (ap_close & (burst_bank_reg == BA_W'(b)));
        assign bank_open_next[b] = (ok_act & hit) ? 1'b1 : (close ? 1'b0 : bank_open_reg[b]);
    end

    // data beats with per-lane byte enables
    wire ddrc_beat_s beat0_next = '{data: dq_rise, be: ~dm_rise, col: seq_col0};
    wire ddrc_beat_s beat1_next = '{data: dq_fall, be: ~dm_fall, col: seq_col1};

    // column order generator
    ddrc_burst_seq #(
        .COL_W(COL_W)
    ) u_seq (
        .clock(clock),
        .nrst(nrst),
        .start(rw_start),
        .start_col(addr[COL_W-1:0]),
        .bc4(use_bc4),
        .interleave(mr_bt_reg),
        .busy(seq_busy),
        .last(seq_last),
        .col0(seq_col0),
        .col1(seq_col1)
    );

    // cke history and power state; cke reads as low out of reset
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cke_prev_reg <= 1'b0;
            pwr_reg <= PS_ON;
            power_down_reg <= 1'b0;
            self_refresh_reg <= 1'b0;
        end else begin
            cke_prev_reg <= cke;
            pwr_reg <= pwr_next;
            power_down_reg <= (pwr_next == PS_PDOWN);
            self_refresh_reg <= (pwr_next == PS_SREF);
        end
    end

    // bank table
    always_ff @(posedge clock) begin
        if (!nrst) begin
            bank_open_reg <= '0;
        end else begin
            bank_open_reg <= bank_open_next;
        end
    end

    // burst field of mode register 0, other mode registers only reported
    always_ff @(posedge clock) begin
        if (!nrst) begin
            mr_bl_reg <= MR_BL_RESET;
            mr_bt_reg <= MR_BT_RESET;
        end else if (ok_mrs && ba == MR0_SEL) begin
            mr_bl_reg <= addr[MR_BL_LSB +: MR_BL_W];
            mr_bt_reg <= addr[MR_BT_BIT];
        end
    end

    // attributes of the burst in flight
    always_ff @(posedge clock) begin
        if (!nrst) begin
            burst_wr_reg <= 1'b0;
            burst_bank_reg <= '0;
            burst_ap_reg <= 1'b0;
        end else if (rw_start) begin
            burst_wr_reg <= ok_wr;
            burst_bank_reg <= ba;
            burst_ap_reg <= addr[AP_BIT];
        end
    end

    // command report
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cmd_valid_reg <= 1'b0;
            cmd_reg <= '0;
            cmd_illegal_reg <= 1'b0;
        end else begin
            cmd_valid_reg <= fire;     // deselect fires only as power-down entry or exit, or as self refresh exit
            cmd_reg <= cmd_next;
            cmd_illegal_reg <= bad;
        end
    end

    // write beats, sampled in the clocks after the write command
    always_ff @(posedge clock) begin
        if (!nrst) begin
            wr_valid_reg <= 1'b0;
            wr_bank_reg <= '0;
            wr_beat0_reg <= '0;
            wr_beat1_reg <= '0;
        end else begin
            wr_valid_reg <= seq_busy & burst_wr_reg;
            wr_bank_reg <= burst_bank_reg;
            wr_beat0_reg <= beat0_next;
            wr_beat1_reg <= beat1_next;
        end
    end

    // read column pairs
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rd_valid_reg <= 1'b0;
            rd_bank_reg <= '0;
            rd_col0_reg <= '0;
            rd_col1_reg <= '0;
        end else begin
            rd_valid_reg <= seq_busy & ~burst_wr_reg;
            rd_bank_reg <= burst_bank_reg;
            rd_col0_reg <= seq_col0;
            rd_col1_reg <= seq_col1;
        end
    end

    // outputs straight from flops
    assign cmd_valid = cmd_valid_reg;
    assign cmd = cmd_reg;
    assign cmd_illegal = cmd_illegal_reg;
    assign bank_open = bank_open_reg;
    assign power_down = power_down_reg;
    assign self_refresh = self_refresh_reg;
    assign wr_valid = wr_valid_reg;
    assign wr_bank = wr_bank_reg;
    assign wr_beat0 = wr_beat0_reg;
    assign wr_beat1 = wr_beat1_reg;
    assign rd_valid = rd_valid_reg;
    assign rd_bank = rd_bank_reg;
    assign rd_col0 = rd_col0_reg;
    assign rd_col1 = rd_col1_reg;

    // checks on the decoder
    desel_ignored_a: assert property (@(posedge clock) disable iff (!nrst)
        (cs_n && cke_prev_reg && cke) |=> !cmd_valid_reg)
        else $error("deselect produced a command");
    act_opens_a: assert property (@(posedge clock) disable iff (!nrst)
        (cmd_valid_reg && cmd_reg.op == OP_ACT) |-> bank_open_reg[cmd_reg.bank])
        else $error("activate left bank closed");
    pre_all_a: assert property (@(posedge clock) disable iff (!nrst)
        (cmd_valid_reg && cmd_reg.op == OP_PREA) |-> (bank_open_reg == '0))
        else $error("precharge all left a bank open");
    mrs_idle_a: assert property (@(posedge clock) disable iff (!nrst)
        (cmd_valid_reg && cmd_reg.op == OP_MRS) |-> ($past(bank_open_reg) == '0))
        else $error("mode set accepted with a bank open");
    wr_bl8_a: assert property (@(posedge clock) disable iff (!nrst)
        (ok_wr && !use_bc4) |-> ##2 wr_valid_reg [*4])
        else $error("full write burst not four clocks");
    wr_bc4_a: assert property (@(posedge clock) disable iff (!nrst)
        (ok_wr && use_bc4) ##1 (!rw_start) [*3] |=> !wr_valid_reg)
        else $error("chopped write burst too long");
    mask_lane_a: assert property (@(posedge clock) disable iff (!nrst)
        wr_valid_reg |-> (wr_beat0_reg.be == ~$past(dm_rise)) && (wr_beat1_reg.be == ~$past(dm_fall)))
        else $error("byte enables do not follow masks");
    auto_close_a: assert property (@(posedge clock) disable iff (!nrst)
        ap_close |=> !bank_open_reg[$past(burst_bank_reg)])
        else $error("auto precharge did not close bank");
    wr_open_a: assert property (@(posedge clock) disable iff (!nrst)
        (cmd_valid_reg && cmd_reg.op == OP_WR) |-> $past(bank_open_reg[ba]))
        else $error("write accepted to idle bank");
    pd_entry_a: assert property (@(posedge clock) disable iff (!nrst)
        (pwr_reg == PS_ON && cke_prev_reg && !cke && idle_cmd) |=> power_down ##1 (power_down || $past(cke)))
        else $error("power-down not entered");
    pd_exit_a: assert property (@(posedge clock) disable iff (!nrst)
        (pwr_reg == PS_PDOWN && !cke_prev_reg && cke && idle_cmd) |=> (pwr_reg == PS_ON))
        else $error("power-down not left");
    cke_low_a: assert property (@(posedge clock) disable iff (!nrst)
        (!cke_prev_reg && !cke) |=> !cmd_valid_reg)
        else $error("command taken with cke low");

    // main scenarios
    wr_ap_c: cover property (@(posedge clock) disable iff (!nrst) ok_wr && addr[AP_BIT] ##[1:8] ap_close);
    sref_c: cover property (@(posedge clock) disable iff (!nrst) do_sre ##[1:20] do_srx);
    rd_bc4_c: cover property (@(posedge clock) disable iff (!nrst) ok_rd && use_bc4 ##2 rd_valid_reg);
endmodule

// *** bench/ddrc_ctl_model.sv ***
// controller model: drives the command bus and the write data lines
module ddrc_ctl_model (
    // command and address
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [ddrc_pkg::BA_W-1:0] ba,
    output logic [ddrc_pkg::ADDR_W-1:0] addr,
    // write data and byte masks
    output logic [ddrc_pkg::DQ_W-1:0] dq_rise,
    output logic [ddrc_pkg::DQ_W-1:0] dq_fall,
    output logic [ddrc_pkg::DM_W-1:0] dm_rise,
    output logic [ddrc_pkg::DM_W-1:0] dm_fall
);
    timeunit 1ns;
    timeprecision 100ps;
    import ddrc_pkg::*;

    // cke held low and device deselected until the bench starts init
    initial begin
        cke = 1'b0;
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = CODE_NOP;
        ba = 3'h0;
        addr = 13'h0000;
        {dq_rise, dq_fall, dm_rise, dm_fall} = '0;
    end

    // one command slot, called at a rising edge
    task automatic drv(input logic k, input logic s, input logic [2:0] c, input logic [2:0] b,
                       input logic [12:0] a);
        cke <= k;
        cs_n <= s;
        // deselected: code lines flip so a stale code never looks valid
        {ras_n, cas_n, we_n} <= s ? ~{ras_n, cas_n, we_n} : c;
        ba <= b;
        addr <= a;
    endtask

    // one word pair, masks high discard a byte lane
    task automatic pair(input logic [15:0] r, input logic [15:0] f, input logic [1:0] mr,
                        input logic [1:0] mf);
        dq_rise <= r;
        dq_fall <= f;
        dm_rise <= mr;
        dm_fall <= mf;
    endtask
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the ddr3 command decoder
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import ddrc_pkg::*;

    // clock, reset and bus
    logic clock, nrst, cke, cs_n, ras_n, cas_n, we_n;
    logic [BA_W-1:0] ba, wr_bank, rd_bank;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq_rise, dq_fall;
    logic [DM_W-1:0] dm_rise, dm_fall;
    // observed outputs
    logic cmd_valid, cmd_illegal, power_down, self_refresh, wr_valid, rd_valid;
    ddrc_cmd_s cmd_out;
    logic [BANKS-1:0] bank_open;
    ddrc_beat_s wr_beat0, wr_beat1;
    logic [COL_W-1:0] rd_col0, rd_col1;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    logic [2:0] mr[4] = '{3'h2, 3'h3, 3'h1, 3'h0};

    ddrc_ctl_model ctl_u (.cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq_rise, .dq_fall,
        .dm_rise, .dm_fall);
    ddrc_decoder dut_u (.clock, .nrst, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq_rise,
        .dq_fall, .dm_rise, .dm_fall, .cmd_valid, .cmd(cmd_out), .cmd_illegal, .bank_open, .power_down,
        .self_refresh, .wr_valid, .wr_bank, .wr_beat0, .wr_beat1, .rd_valid, .rd_bank, .rd_col0, .rd_col1);

    // 4 ns clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // hang guard, tests need about a hundred cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            wrap_up();
        end
    end

    // counts, verdict and end of run
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // one comparison of any result
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // column of beat i in sequential order
    function automatic logic [9:0] colx(input logic [9:0] c, input logic [2:0] i);
        return {c[9:3], c[2] ^ i[2], c[1:0] + i[1:0]};
    endfunction

    // word pair j on the data lines
    task automatic putp(input int j);
        ctl_u.pair(16'hA5A0 ^ 16'(j), 16'h5A50 ^ 16'(j), 2'(j), ~2'(j));
    endtask

    // one command then deselect; returns just after the answer lands
    task automatic cmd(input logic k, input logic s, input logic [2:0] c, input logic [2:0] b,
                       input logic [12:0] a);
        @(posedge clock);
        ctl_u.drv(k, s, c, b, a);
        @(posedge clock);
        ctl_u.drv(k, 1'b1, c, b, a);
        putp(0);
        #1;
    endtask

    // accepted/refused pulses and decoded operation
    task automatic ck(input logic [1:0] vi, input ddrc_op_e op);
        chk({cmd_valid, cmd_illegal}, vi);
        if (vi[1]) chk(cmd_out.op, op);
    endtask

    // init sequence: mode registers, long and short calibration, nop
    task automatic t_init();
        chk({bank_open, power_down, self_refresh}, 0);
        cmd(1, 1, CODE_NOP, 3'h0, 13'h0000);
        cmd(1, 1, CODE_NOP, 3'h0, 13'h0000);
        foreach (mr[i]) begin
            cmd(1, 0, CODE_MRS, mr[i], 13'h0001);
            ck(2'b10, OP_MRS);
        end
        cmd(1, 0, CODE_ZQ, 3'h0, 13'h0400);
        ck(2'b10, OP_ZQL);
        cmd(1, 0, CODE_ZQ, 3'h0, 13'h0000);
        ck(2'b10, OP_ZQS);
        cmd(1, 0, CODE_NOP, 3'h0, 13'h0000);
        ck(2'b10, OP_NOP);
        chk(bank_open, 0);
        $display("init test done");
    endtask

    // activate, deselect masking and per-bank legality
    task automatic t_act();
        cmd(1, 1, CODE_ACT, 3'h5, 13'h0FFF);
        ck(2'b00, OP_NOP);
        cmd(1, 0, CODE_ACT, 3'h5, 13'h0FFF);
        ck(2'b10, OP_ACT);
        chk({bank_open, cmd_out.bank, cmd_out.addr[11:0]}, {8'h20, 3'h5, 12'hFFF});
        cmd(1, 0, CODE_ACT, 3'h5, 13'h0000);
        ck(2'b01, OP_NOP);
        cmd(1, 0, CODE_MRS, 3'h0, 13'h0001);
        ck(2'b01, OP_NOP);
        cmd(1, 0, CODE_REF, 3'h0, 13'h0000);
        ck(2'b01, OP_NOP);
        cmd(1, 0, CODE_RD, 3'h2, 13'h0000);
        ck(2'b01, OP_NOP);
        $display("activate test done");
    endtask

    // bl8 write with masks and auto precharge to open bank 5
    task automatic t_wr();
        cmd(1, 0, CODE_WR, 3'h5, 13'h1405);
        ck(2'b10, OP_WR);
        chk({cmd_out.ap, cmd_out.bc4}, 2'b10);
        for (int k = 1; k <= 4; k++) begin
            @(posedge clock);
            if (k < 4) putp(k);
            #1;
            chk({wr_valid, wr_bank}, 4'hD);
            chk(wr_beat0, {16'hA5A0 ^ 16'(k - 1), ~2'(k - 1), colx(10'h005, 3'(2 * k - 2))});
            chk(wr_beat1, {16'h5A50 ^ 16'(k - 1), 2'(k - 1), colx(10'h005, 3'(2 * k - 1))});
        end
        chk(bank_open, 0);
        @(posedge clock);
        #1;
        chk(wr_valid, 0);
        $display("write test done");
    endtask

    // bc4 read with auto precharge, then fixed bl8 ignores a12
    task automatic t_rd();
        cmd(1, 0, CODE_ACT, 3'h3, 13'h0000);
        cmd(1, 0, CODE_RD, 3'h3, 13'h0406);
        ck(2'b10, OP_RD);
        chk({cmd_out.ap, cmd_out.bc4}, 2'b11);
        for (int k = 1; k <= 3; k++) begin
            @(posedge clock);
            #1;
            chk({rd_valid, rd_bank}, {k < 3, 3'h3});
            if (k < 3) chk({rd_col0, rd_col1}, {colx(10'h006, 3'(2 * k - 2)), colx(10'h006, 3'(2 * k - 1))});
        end
        repeat (3) @(posedge clock);
        #1;
        chk(bank_open, 0);
        cmd(1, 0, CODE_MRS, 3'h0, 13'h0000);
        cmd(1, 0, CODE_ACT, 3'h3, 13'h0000);
        cmd(1, 0, CODE_RD, 3'h3, 13'h0000);
        chk(cmd_out.bc4, 0);
        cmd(1, 0, CODE_ACT, 3'h1, 13'h0000);
        cmd(1, 0, CODE_PRE, 3'h3, 13'h0000);
        ck(2'b10, OP_PRE);
        chk(bank_open, 8'h02);
        cmd(1, 0, CODE_PRE, 3'h0, 13'h0400);
        ck(2'b10, OP_PREA);
        chk(bank_open, 0);
        // fixed bc4 with interleaved order: a12 high must not lengthen the burst
        cmd(1, 0, CODE_MRS, 3'h0, 13'h000A);
        cmd(1, 0, CODE_ACT, 3'h2, 13'h0000);
        cmd(1, 0, CODE_RD, 3'h2, 13'h1005);
        chk(cmd_out.bc4, 1);
        @(posedge clock);
        #1;
        chk({rd_col0, rd_col1}, {10'h005, 10'h004});
        cmd(1, 0, CODE_WR, 3'h2, 13'h0008);
        repeat (2) @(posedge clock);
        #1;
        chk({wr_valid, wr_beat1.col}, {1'b1, 10'h00B});
        @(posedge clock);
        #1;
        chk(wr_valid, 0);
        cmd(1, 0, CODE_PRE, 3'h2, 13'h0000);
        ck(2'b10, OP_PRE);
        $display("read test done");
    endtask

    // refresh, power-down and self refresh by cke edges
    task automatic t_pwr();
        cmd(1, 0, CODE_REF, 3'h0, 13'h0000);
        ck(2'b10, OP_REF);
        cmd(0, 0, CODE_NOP, 3'h0, 13'h0000);
        ck(2'b10, OP_PDE);
        chk(power_down, 1);
        cmd(1, 1, CODE_NOP, 3'h0, 13'h0000);
        ck(2'b10, OP_PDX);
        chk(power_down, 0);
        cmd(0, 0, CODE_REF, 3'h0, 13'h0000);
        ck(2'b10, OP_SRE);
        chk(self_refresh, 1);
        cmd(1, 1, CODE_NOP, 3'h0, 13'h0000);
        ck(2'b10, OP_SRX);
        chk(self_refresh, 0);
        // cke falling with a real command is refused and changes no state
        cmd(0, 0, CODE_ACT, 3'h0, 13'h0000);
        ck(2'b01, OP_NOP);
        chk({power_down, bank_open}, 0);
        $display("power test done");
    endtask

    // reset for 8 cycles, then the tests in order
    initial begin
        nrst = 1'b0;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        #1;
        t_init();
        t_act();
        t_wr();
        t_rd();
        t_pwr();
        wrap_up();
    end
endmodule
